/* File: hdl/lesc_regs.sv */
// Line event status, mask, error count and mode registers on classic Wishbone
`timescale 1ns/100ps
`default_nettype none

module lesc_regs
#(
  parameter int unsigned ROUND_CYCLES = lesc_pkg::ROUND_CYCLES_DEF
)
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic  [lesc_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic  [lesc_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic  [lesc_pkg::DAT_W-1:0]   wb_dat_i,
  output logic       [lesc_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          sys_bipolar_violation_i,
  input  wire logic                          line_bipolar_violation_i,
  input  wire logic                          sys_excess_zero_i,
  input  wire logic                          line_excess_zero_i,
  input  wire logic                          pattern_error_i,
  input  wire logic                          error_event_i,
  output logic                               int_n_o
);
  import lesc_pkg::*;

  localparam logic [ROUND_CNT_W-1:0] ROUND_LAST = ROUND_CNT_W'(ROUND_CYCLES - 1);
  localparam logic [ROUND_CNT_W-1:0] ROUND_ZERO = '0;
  localparam logic [ROUND_CNT_W-1:0] ROUND_ONE  = ROUND_CNT_W'(1);

  logic [BYTE_W-1:0]      interrupt_status_two;
  logic [BYTE_W-1:0]      interrupt_mask;
  lesc_mode_t             count_update_mode;
  logic [BYTE_W-1:0]      next_status;
  logic [BYTE_W-1:0]      event_set;
  logic [BYTE_W-1:0]      status_clear;
  logic [DAT_W-1:0]       next_rdata;
  logic [ROUND_CNT_W-1:0] round_count;
  logic                   round_tick;
  logic                   manual_req;
  logic                   update_pulse;
  logic                   counter_overflow;
  logic [COUNT_W-1:0]     error_count_value;
  logic                   wb_req;
  logic                   wr_en;

  function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
    reg_hit = (adr == ofs);
  endfunction

  // Bus handshake: one wait state, ack drops the cycle after it was given
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wr_en  = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  // Read mux; unmapped offsets answer with zero
  always_comb
  begin
    next_rdata = DAT_ZERO;
    if (reg_hit(wb_adr_i, OFS_STATUS))
    begin
      next_rdata = {PAD_ZERO, interrupt_status_two & STATUS_USED};
    end
    else if (reg_hit(wb_adr_i, OFS_MASK))
    begin
      next_rdata = {PAD_ZERO, interrupt_mask & STATUS_USED};
    end
    else if (reg_hit(wb_adr_i, OFS_ERR_LOW))
    begin
      next_rdata = {PAD_ZERO, error_count_value[BYTE_W-1:0]};
    end
    else if (reg_hit(wb_adr_i, OFS_ERR_HIGH))
    begin
      next_rdata = {PAD_ZERO, error_count_value[COUNT_W-1:BYTE_W]};
    end
    else if (reg_hit(wb_adr_i, OFS_CONFIG))
    begin
      next_rdata[CFG_MODE_BIT] = count_update_mode;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= DAT_ZERO;
    end
    else if (wb_req && !wb_ack_o && !wb_we_i)
    begin
      wb_dat_o <= next_rdata;
    end
  end

  // Event sources gathered into the status layout
  always_comb
  begin
    event_set = STATUS_RESET;
    event_set[BIT_SYS_BPV]  = sys_bipolar_violation_i;
    event_set[BIT_LINE_BPV] = line_bipolar_violation_i;
    event_set[BIT_SYS_EXZ]  = sys_excess_zero_i;
    event_set[BIT_LINE_EXZ] = line_excess_zero_i;
    event_set[BIT_PAT_ERR]  = pattern_error_i;
    event_set[BIT_CNT_OVF]  = counter_overflow;
  end

  always_comb
  begin
    status_clear = STATUS_RESET;
    if (wr_en && reg_hit(wb_adr_i, OFS_STATUS))
    begin
      status_clear = wb_dat_i[BYTE_W-1:0] & STATUS_USED;
    end
  end

  // Set beats clear so an event landing on a clear write is not lost
  assign next_status = ((interrupt_status_two & ~status_clear) | event_set) & STATUS_USED;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      interrupt_status_two <= STATUS_RESET;
    end
    else
    begin
      interrupt_status_two <= next_status;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      interrupt_mask <= MASK_RESET;
    end
    else if (wr_en && reg_hit(wb_adr_i, OFS_MASK))
    begin
      interrupt_mask <= wb_dat_i[BYTE_W-1:0] & STATUS_USED;
    end
  end

  // Pin is driven low while any enabled status bit is still latched
  assign int_n_o = ~|(interrupt_status_two & interrupt_mask);

  // Mode register; the update bit is a strobe and reads back zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_update_mode <= lesc_mode_t'(MODE_RESET);
    end
    else if (wr_en && reg_hit(wb_adr_i, OFS_CONFIG))
    begin
      count_update_mode <= lesc_mode_t'(wb_dat_i[CFG_MODE_BIT]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      manual_req <= 1'b0;
    end
    else
    begin
      manual_req <= wr_en && reg_hit(wb_adr_i, OFS_CONFIG) && wb_dat_i[CFG_UPDATE_BIT]
                    && (wb_dat_i[CFG_MODE_BIT] == LESC_MODE_MANUAL);
    end
  end

  // Round divider runs only in automatic mode and restarts on mode entry
  always_ff @(posedge clk_i)
  begin
    if (rst_i || count_update_mode == LESC_MODE_MANUAL)
    begin
      round_count <= ROUND_ZERO;
    end
    else if (round_count == ROUND_LAST)
    begin
      round_count <= ROUND_ZERO;
    end
    else
    begin
      round_count <= round_count + ROUND_ONE;
    end
  end

  assign round_tick = (count_update_mode == LESC_MODE_AUTO) && (round_count == ROUND_LAST);

  always_comb
  begin
    unique case (count_update_mode)
      LESC_MODE_AUTO:
      begin
        update_pulse = round_tick;
      end
      LESC_MODE_MANUAL:
      begin
        update_pulse = manual_req;
      end
    endcase
  end

  lesc_err_counter u_err_counter
  (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .error_event_i (error_event_i),
    .update_i      (update_pulse),
    .count_o       (error_count_value),
    .overflow_o    (counter_overflow)
  );

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic status_wr_now;
  assign status_wr_now = wr_en && reg_hit(wb_adr_i, OFS_STATUS);

  sys_bpv_set_a: assert property (sys_bipolar_violation_i |=> interrupt_status_two[BIT_SYS_BPV])
    else $error("system bipolar flag not set");
  sys_bpv_clear_a: assert property (
    interrupt_status_two[BIT_SYS_BPV] && status_wr_now && wb_dat_i[BIT_SYS_BPV]
    && !sys_bipolar_violation_i |=> !interrupt_status_two[BIT_SYS_BPV])
    else $error("system bipolar flag not cleared");
  line_bpv_set_a: assert property (line_bipolar_violation_i |=> interrupt_status_two[BIT_LINE_BPV])
    else $error("line bipolar flag not set");
  sys_exz_hold_a: assert property (
    interrupt_status_two[BIT_SYS_EXZ] && !status_wr_now |=> interrupt_status_two[BIT_SYS_EXZ])
    else $error("system excess zero flag dropped");
  sys_exz_set_a: assert property (sys_excess_zero_i |=> interrupt_status_two[BIT_SYS_EXZ])
    else $error("system excess zero flag not set");
  line_exz_set_a: assert property (line_excess_zero_i |=> interrupt_status_two[BIT_LINE_EXZ])
    else $error("line excess zero flag not set");
  pattern_err_set_a: assert property (pattern_error_i |=> interrupt_status_two[BIT_PAT_ERR])
    else $error("pattern error flag not set");
  overflow_wrap_a: assert property (
    error_event_i && !update_pulse && u_err_counter.running == COUNT_MAX
    |=> ##1 interrupt_status_two[BIT_CNT_OVF])
    else $error("overflow flag not set after wrap");
  err_low_read_a: assert property (
    wb_req && !wb_we_i && !wb_ack_o && reg_hit(wb_adr_i, OFS_ERR_LOW) && !update_pulse
    |=> wb_ack_o && wb_dat_o == {PAD_ZERO, error_count_value[BYTE_W-1:0]})
    else $error("low byte read mismatch");
  count_latch_a: assert property (
    update_pulse |=> error_count_value == $past(u_err_counter.running))
    else $error("count not latched on update");
  count_stable_a: assert property (!update_pulse |=> $stable(error_count_value))
    else $error("count changed without update");
  // Age since the last update, kept apart from the divider so a wrong period shows up
  logic [ROUND_CNT_W-1:0] auto_age;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || count_update_mode == LESC_MODE_MANUAL || update_pulse)
    begin
      auto_age <= ROUND_ZERO;
    end
    else
    begin
      auto_age <= auto_age + ROUND_ONE;
    end
  end

  auto_period_a: assert property (
    count_update_mode == LESC_MODE_AUTO |-> update_pulse == (auto_age == ROUND_LAST))
    else $error("automatic update off period");
  reserved_zero_a: assert property (interrupt_status_two[BIT_RSVD_HI:BIT_RSVD_LO] == 2'b00)
    else $error("reserved status bits set");
  int_follow_a: assert property (
    $rose(|(interrupt_status_two & interrupt_mask)) |-> $fell(int_n_o))
    else $error("interrupt pin did not assert");
  int_release_a: assert property (
    (interrupt_status_two & interrupt_mask) == STATUS_RESET |-> int_n_o)
    else $error("interrupt pin stuck low");

  bpv_cleared_c: cover property (
    interrupt_status_two[BIT_SYS_BPV] ##1 status_wr_now ##1 !interrupt_status_two[BIT_SYS_BPV]);
  overflow_c: cover property (counter_overflow);
  manual_update_c: cover property (manual_req);
  auto_update_c: cover property (round_tick);
  set_beats_clear_c: cover property (status_wr_now && (event_set & status_clear) != STATUS_RESET);

endmodule

`default_nettype wire

/* File: shared/lesc_pkg.sv */
// Constants for the line event status and error count register slice
package lesc_pkg;

  // Clock and automatic counting round
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned ROUND_TIME_MS    = 1000;
  localparam int unsigned NS_PER_MS        = 1000000;
  localparam int unsigned ROUND_CYCLES_DEF = ROUND_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned ROUND_CNT_W      = 25;

  // Bus geometry
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned SEL_W  = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned COUNT_W = 16;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_STATUS   = 8'h00;
  localparam logic [ADR_W-1:0] OFS_MASK     = 8'h04;
  localparam logic [ADR_W-1:0] OFS_ERR_LOW  = 8'h08;
  localparam logic [ADR_W-1:0] OFS_ERR_HIGH = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_CONFIG   = 8'h10;

  // Status and mask field positions
  localparam int unsigned BIT_SYS_BPV   = 5;
  localparam int unsigned BIT_LINE_BPV  = 4;
  localparam int unsigned BIT_SYS_EXZ   = 3;
  localparam int unsigned BIT_LINE_EXZ  = 2;
  localparam int unsigned BIT_PAT_ERR   = 1;
  localparam int unsigned BIT_CNT_OVF   = 0;
  localparam int unsigned BIT_RSVD_LO   = 6;
  localparam int unsigned BIT_RSVD_HI   = 7;

  localparam logic [BYTE_W-1:0] STATUS_USED  = 8'h3f;
  localparam logic [BYTE_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] MASK_RESET   = 8'h3f;

  // Configuration fields
  localparam int unsigned CFG_MODE_BIT   = 0;
  localparam int unsigned CFG_UPDATE_BIT = 1;
  localparam logic        MODE_RESET     = 1'b0;

  localparam logic [DAT_W-1:0]   DAT_ZERO   = 32'h0000_0000;
  localparam logic [DAT_W-BYTE_W-1:0] PAD_ZERO = 24'h00_0000;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE  = 16'h0001;
  localparam logic [COUNT_W-1:0] COUNT_MAX  = 16'hffff;

  // Count update mode encoding
  typedef enum logic
  {
    LESC_MODE_MANUAL = 1'b0,
    LESC_MODE_AUTO   = 1'b1
  } lesc_mode_t;

endpackage

/* File: hdl/lesc_err_counter.sv */
// Error counter with latched readable value and overflow pulse
`timescale 1ns/100ps
`default_nettype none

module lesc_err_counter
(
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           error_event_i,
  input  wire logic                           update_i,
  output logic       [lesc_pkg::COUNT_W-1:0]  count_o,
  output logic                                overflow_o
);
  import lesc_pkg::*;

  logic [COUNT_W-1:0] running;

  // Running count restarts at each update, keeping an event of that cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      running <= COUNT_ZERO;
    end
    else if (update_i)
    begin
      running <= error_event_i ? COUNT_ONE : COUNT_ZERO;
    end
    else if (error_event_i)
    begin
      running <= running + COUNT_ONE;
    end
  end

  // Unread value is replaced at the next update
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_o <= COUNT_ZERO;
    end
    else if (update_i)
    begin
      count_o <= running;
    end
  end

  // Wrap past all ones is reported once per wrap
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overflow_o <= 1'b0;
    end
    else
    begin
      overflow_o <= error_event_i && !update_i && (running == COUNT_MAX);
    end
  end

endmodule

`default_nettype wire

/* File: verification/line_event_status_and_error_count_tb.sv */
// Self-checking bench for the line event status and error count slice
`timescale 1ns/100ps
`default_nettype none

module line_event_status_and_error_count_tb;
  import lesc_pkg::*;
  // Short round keeps the automatic update test brief
  localparam int unsigned ROUND = 20;

  logic             clk_i;
  logic             rst_i;
  logic             cyc;
  logic             stb;
  logic             we;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat;
  logic [DAT_W-1:0] rdat;
  logic             ack;
  logic [4:0]       ev;
  logic             err_ev;
  logic             int_n;
  int               err_count;
  int               check_count;

  lesc_regs #(.ROUND_CYCLES(ROUND)) i_dut
  (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .wb_cyc_i                 (cyc),
    .wb_stb_i                 (stb),
    .wb_we_i                  (we),
    .wb_adr_i                 (adr),
    .wb_sel_i                 (4'h1),
    .wb_dat_i                 (wdat),
    .wb_dat_o                 (rdat),
    .wb_ack_o                 (ack),
    .sys_bipolar_violation_i  (ev[4]),
    .line_bipolar_violation_i (ev[3]),
    .sys_excess_zero_i        (ev[2]),
    .line_excess_zero_i       (ev[1]),
    .pattern_error_i          (ev[0]),
    .error_event_i            (err_ev),
    .int_n_o                  (int_n)
  );

  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check_word(input string name, input logic [DAT_W-1:0] e,
                            input logic [DAT_W-1:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_pin(input string name, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %b seen %b", name, e, g);
    end
  endtask

  // One classic cycle; request held until ack is sampled high, a hang is left to the watchdog
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [BYTE_W-1:0] d,
                    output logic [DAT_W-1:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {PAD_ZERO, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
    begin
      @(posedge clk_i);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [BYTE_W-1:0] d);
    logic [DAT_W-1:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input string name, input logic [ADR_W-1:0] a, input logic [BYTE_W-1:0] e);
    logic [DAT_W-1:0] q;
    wb(1'b0, a, 8'h00, q);
    check_word(name, {PAD_ZERO, e}, q);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic hold_err(input int n);
    @(posedge clk_i);
    err_ev <= 1'b1;
    repeat (n) @(posedge clk_i);
    err_ev <= 1'b0;
  endtask

  task automatic manual_update();
    wr(OFS_CONFIG, 8'h02);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic test_reset_values();
    check_pin("int_n after reset", 1'b1, int_n);
    rd("status reset", OFS_STATUS, 8'h00);
    rd("mask reset", OFS_MASK, 8'h3f);
    rd("count low reset", OFS_ERR_LOW, 8'h00);
    rd("count high reset", OFS_ERR_HIGH, 8'h00);
    rd("config reset", OFS_CONFIG, 8'h00);
    wr(8'h20, 8'hff);
    rd("unmapped read", 8'h20, 8'h00);
    wr(OFS_ERR_LOW, 8'h5a);
    rd("count low read only", OFS_ERR_LOW, 8'h00);
  endtask

  task automatic test_sticky_bits();
    logic [BYTE_W-1:0] b;
    for (int i = 0; i < 5; i++)
    begin
      b = 8'h02 << i;
      pulse(i);
      check_pin("int_n on event", 1'b0, int_n);
      rd("status after event", OFS_STATUS, b);
      wr(OFS_STATUS, ~b);
      rd("status after other ones", OFS_STATUS, b);
      wr(OFS_STATUS, b);
      rd("status after clear", OFS_STATUS, 8'h00);
      check_pin("int_n after clear", 1'b1, int_n);
    end
  endtask

  task automatic test_mask_and_reserved();
    wr(OFS_MASK, 8'h00);
    rd("mask readback", OFS_MASK, 8'h00);
    pulse(4);
    pulse(3);
    check_pin("int_n masked", 1'b1, int_n);
    rd("status while masked", OFS_STATUS, 8'h30);
    wr(OFS_MASK, 8'hff);
    #1;
    check_pin("int_n unmasked", 1'b0, int_n);
    rd("mask reserved bits", OFS_MASK, 8'h3f);
    wr(OFS_STATUS, 8'h10);
    #1;
    check_pin("int_n one bit left", 1'b0, int_n);
    rd("status one bit left", OFS_STATUS, 8'h20);
    wr(OFS_STATUS, 8'hff);
    rd("status all cleared", OFS_STATUS, 8'h00);
    check_pin("int_n all cleared", 1'b1, int_n);
  endtask

  task automatic test_manual_count();
    manual_update();
    rd("config strobe reads zero", OFS_CONFIG, 8'h00);
    hold_err(259);
    rd("count held until update", OFS_ERR_LOW, 8'h00);
    manual_update();
    rd("count low byte", OFS_ERR_LOW, 8'h03);
    rd("count high byte", OFS_ERR_HIGH, 8'h01);
  endtask

  task automatic test_auto_count();
    wr(OFS_CONFIG, 8'h01);
    hold_err(5);
    // Read lands after the first round end but before the second
    repeat (16) @(posedge clk_i);
    rd("auto count low", OFS_ERR_LOW, 8'h05);
    rd("config auto", OFS_CONFIG, 8'h01);
    wr(OFS_CONFIG, 8'h00);
  endtask

  task automatic test_overflow();
    manual_update();
    hold_err(65536);
    repeat (4) @(posedge clk_i);
    #1;
    check_pin("int_n on overflow", 1'b0, int_n);
    rd("status overflow", OFS_STATUS, 8'h01);
    manual_update();
    rd("wrapped count low", OFS_ERR_LOW, 8'h00);
    rd("wrapped count high", OFS_ERR_HIGH, 8'h00);
    wr(OFS_STATUS, 8'h01);
    rd("overflow cleared", OFS_STATUS, 8'h00);
    check_pin("int_n overflow cleared", 1'b1, int_n);
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    $display("unexpected run length: expected end seen watchdog");
    tally_and_finish();
  end

  initial
  begin
    err_count = 0;
    check_count = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = DAT_ZERO;
    ev = 5'h00;
    err_ev = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset_values();
    test_sticky_bits();
    test_mask_and_reserved();
    test_manual_count();
    test_auto_count();
    test_overflow();
    tally_and_finish();
  end
endmodule

`default_nettype wire
